// ==== rtl/sicb_bank.sv ====
// interrupt-enable and channel-configuration register bank
`timescale 1ns/1ps
// What this block does
// - hf overvoltage enable per channel, eight bits
// - lf overvoltage enable per channel, eight bits
// - power-on sequence enables, channels one to six
// - power-off sequence enables, top bits reserved
// - sleep-exit sequence enables, channels one to six
// - sleep-entry sequence enables, channels one to six
// - control bit 4 enables checksum fault
// - control bit 2 enables overtemperature fault
// - control bit 1 enables sync pin fault
// - control bit 0 enables packet check fault
// - test bit 3 enables corrected bit
// - test bit 1 enables selftest done
// - test bit 0 enables selftest fail
// - vendor enable register fully reserved, read-only
// - monitor enable per channel, eight bits
// - range bit selects 1x or 4x scaling
// - overvoltage enables reset to zero
// - threshold code decoded per range bit
module sicb_bank (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [7:0] ovhf_fault_in,
  input wire logic [7:0] ovlf_fault_in,
  input wire logic [5:0] seq_on_fault_in,
  input wire logic [5:0] seq_off_fault_in,
  input wire logic [5:0] slp_exit_fault_in,
  input wire logic [5:0] slp_entry_fault_in,
  input wire logic checksum_fault_in,
  input wire logic overtemp_fault_in,
  input wire logic sync_pin_fault_in,
  input wire logic packet_check_fault_in,
  input wire logic corrected_bit_fault_in,
  input wire logic selftest_done_in,
  input wire logic selftest_fail_in,
  input wire logic [2:0] thr_ch_in,
  input wire logic [7:0] thr_code_in,
  output logic [12:0] thr_mv_out,
  output logic [7:0] channel_monitor_enable_out,
  output logic [7:0] channel_range_scaling_out,
  output logic irq_n_out,
  output logic irq_oe_out
);
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic sicb_pkg::sicb_idx_t sicb_decode(input logic [7:0] a);
    if (a == sicb_pkg::OFF_OVHF)
      return sicb_pkg::SICB_IDX_OVHF;
    else if (a == sicb_pkg::OFF_OVLF)
      return sicb_pkg::SICB_IDX_OVLF;
    else if (a == sicb_pkg::OFF_SEQ_ON)
      return sicb_pkg::SICB_IDX_SEQ_ON;
    else if (a == sicb_pkg::OFF_SEQ_OFF)
      return sicb_pkg::SICB_IDX_SEQ_OFF;
    else if (a == sicb_pkg::OFF_SLP_EXIT)
      return sicb_pkg::SICB_IDX_SLP_EXIT;
    else if (a == sicb_pkg::OFF_SLP_ENTRY)
      return sicb_pkg::SICB_IDX_SLP_ENTRY;
    else if (a == sicb_pkg::OFF_CONTROL)
      return sicb_pkg::SICB_IDX_CONTROL;
    else if (a == sicb_pkg::OFF_TEST)
      return sicb_pkg::SICB_IDX_TEST;
    else if (a == sicb_pkg::OFF_VENDOR)
      return sicb_pkg::SICB_IDX_VENDOR;
    else if (a == sicb_pkg::OFF_MON_EN)
      return sicb_pkg::SICB_IDX_MON_EN;
    else if (a == sicb_pkg::OFF_RANGE)
      return sicb_pkg::SICB_IDX_RANGE;
    else
      return sicb_pkg::SICB_IDX_NONE;
  endfunction

  function automatic logic [7:0] sicb_mask(input sicb_pkg::sicb_idx_t i);
    logic [7:0] m;
    m = sicb_pkg::MASK_FULL;
    case (i)
      sicb_pkg::SICB_IDX_SEQ_ON,
      sicb_pkg::SICB_IDX_SEQ_OFF,
      sicb_pkg::SICB_IDX_SLP_EXIT,
      sicb_pkg::SICB_IDX_SLP_ENTRY: m = sicb_pkg::MASK_SEQ;
      sicb_pkg::SICB_IDX_CONTROL: m = sicb_pkg::MASK_CONTROL;
      sicb_pkg::SICB_IDX_TEST: m = sicb_pkg::MASK_TEST;
      sicb_pkg::SICB_IDX_VENDOR: m = sicb_pkg::MASK_VENDOR;
      sicb_pkg::SICB_IDX_NONE: m = 8'h00;
      default: m = sicb_pkg::MASK_FULL;
    endcase
    return m;
  endfunction

  sicb_pkg::sicb_idx_t wr_idx;
  sicb_pkg::sicb_idx_t rd_idx;
  logic [87:0] regs;
  logic [7:0] en_ovhf;
  logic [7:0] en_ovlf;
  logic [7:0] en_son;
  logic [7:0] en_soff;
  logic [7:0] en_sex;
  logic [7:0] en_sen;
  logic [7:0] en_ctl;
  logic [7:0] en_tst;
  logic [63:0] faults;
  logic [63:0] enables;

  assign wr_idx = sicb_decode(addr_in);
  assign rd_idx = sicb_decode(addr_in);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  // mask applied on both write and read, so reserved bits stay zero
  sicb_reg_mem u_mem (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .wr_en_in(wr_in),
    .wr_idx_in(4'(wr_idx)),
    .wr_data_in(wdata_in),
    .wr_mask_in(sicb_mask(wr_idx)),
    .rd_en_in(rd_in),
    .rd_idx_in(4'(rd_idx)),
    .rd_mask_in(sicb_mask(rd_idx)),
    .rd_data_out(rdata_out),
    .all_regs_out(regs)
  );

  assign en_ovhf = regs[int'(sicb_pkg::SICB_IDX_OVHF)*8 +: 8];
  assign en_ovlf = regs[int'(sicb_pkg::SICB_IDX_OVLF)*8 +: 8];
  assign en_son = regs[int'(sicb_pkg::SICB_IDX_SEQ_ON)*8 +: 8];
  assign en_soff = regs[int'(sicb_pkg::SICB_IDX_SEQ_OFF)*8 +: 8];
  assign en_sex = regs[int'(sicb_pkg::SICB_IDX_SLP_EXIT)*8 +: 8];
  assign en_sen = regs[int'(sicb_pkg::SICB_IDX_SLP_ENTRY)*8 +: 8];
  assign en_ctl = regs[int'(sicb_pkg::SICB_IDX_CONTROL)*8 +: 8];
  assign en_tst = regs[int'(sicb_pkg::SICB_IDX_TEST)*8 +: 8];
  assign channel_monitor_enable_out = regs[int'(sicb_pkg::SICB_IDX_MON_EN)*8 +: 8];
  assign channel_range_scaling_out = regs[int'(sicb_pkg::SICB_IDX_RANGE)*8 +: 8];

  // ----------------------------------------
  // interrupt gating
  // ----------------------------------------
  // faults and enables packed in matching lanes; unused lanes zero
  assign faults = {ovhf_fault_in, ovlf_fault_in,
                   2'b00, seq_on_fault_in, 2'b00, seq_off_fault_in,
                   2'b00, slp_exit_fault_in, 2'b00, slp_entry_fault_in,
                   3'b000, checksum_fault_in, 1'b0, overtemp_fault_in,
                   sync_pin_fault_in, packet_check_fault_in,
                   4'h0, corrected_bit_fault_in, 1'b0,
                   selftest_done_in, selftest_fail_in};
  assign enables = {en_ovhf, en_ovlf, en_son, en_soff, en_sex, en_sen,
                    en_ctl, en_tst};

  sicb_irq_gate u_irq (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .fault_in(faults),
    .enable_in(enables),
    .irq_n_out(irq_n_out),
    .irq_oe_out(irq_oe_out)
  );

  // ----------------------------------------
  // threshold decode
  // ----------------------------------------
  // registered; one cycle behind the code/channel inputs
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      thr_mv_out <= 13'h0000;
    else if (channel_range_scaling_out[thr_ch_in])
      thr_mv_out <= 13'(sicb_pkg::BASE_4X_MV + sicb_pkg::STEP_4X_MV * int'(thr_code_in));
    else
      thr_mv_out <= 13'(sicb_pkg::BASE_1X_MV + sicb_pkg::STEP_1X_MV * int'(thr_code_in));
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ovhf_reset: assert property (
    @(posedge clk_sys_in)
    $rose(arst_n_in)
    |-> (en_ovhf == 8'h00 && en_ovlf == 8'h00))
    else $error("overvoltage enables not zero after reset");
  a_ovhf_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && addr_in == sicb_pkg::OFF_OVHF)
    |=> en_ovhf == $past(wdata_in))
    else $error("hf enable write lost");
  a_ovlf_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && addr_in == sicb_pkg::OFF_OVLF)
    |=> en_ovlf == $past(wdata_in))
    else $error("lf enable write lost");
  a_son_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && addr_in == sicb_pkg::OFF_SEQ_ON)
    |=> en_son == ($past(wdata_in) & sicb_pkg::MASK_SEQ))
    else $error("power-on enable write wrong");
  a_soff_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && addr_in == sicb_pkg::OFF_SEQ_OFF)
    |=> en_soff == ($past(wdata_in) & sicb_pkg::MASK_SEQ))
    else $error("power-off enable write wrong");
  a_sex_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && addr_in == sicb_pkg::OFF_SLP_EXIT)
    |=> en_sex == ($past(wdata_in) & sicb_pkg::MASK_SEQ))
    else $error("sleep-exit enable write wrong");
  a_sen_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && addr_in == sicb_pkg::OFF_SLP_ENTRY)
    |=> en_sen == ($past(wdata_in) & sicb_pkg::MASK_SEQ))
    else $error("sleep-entry enable write wrong");
  a_ctl_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && addr_in == sicb_pkg::OFF_CONTROL)
    |=> en_ctl == ($past(wdata_in) & sicb_pkg::MASK_CONTROL))
    else $error("control enable write wrong");
  a_test_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && addr_in == sicb_pkg::OFF_TEST)
    |=> en_tst == ($past(wdata_in) & sicb_pkg::MASK_TEST))
    else $error("test enable write wrong");
  a_mon_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && addr_in == sicb_pkg::OFF_MON_EN)
    |=> channel_monitor_enable_out == $past(wdata_in))
    else $error("monitor enable write lost");
  a_range_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && addr_in == sicb_pkg::OFF_RANGE)
    |=> channel_range_scaling_out == $past(wdata_in))
    else $error("range write lost");
  a_seq_reserved: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (en_son[7:6] == 2'b00 && en_soff[7:6] == 2'b00
     && en_sex[7:6] == 2'b00 && en_sen[7:6] == 2'b00))
    else $error("sequence reserved bits set");
  a_ctl_reserved: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (en_ctl[7:5] == 3'b000 && en_ctl[3] == 1'b0))
    else $error("control reserved bits set");
  a_test_reserved: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (en_tst[7:4] == 4'h0 && en_tst[2] == 1'b0))
    else $error("test reserved bits set");
  a_vendor_zero: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rd_in && addr_in == sicb_pkg::OFF_VENDOR)
    |=> rdata_out == 8'h00)
    else $error("vendor register read nonzero");
  a_read_back: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rd_in && addr_in == sicb_pkg::OFF_MON_EN)
    |=> rdata_out == channel_monitor_enable_out)
    else $error("monitor enable readback wrong");
  a_unmapped_read: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (rd_in && addr_in == 8'h20)
    |=> rdata_out == 8'h00)
    else $error("unmapped read nonzero");
  a_unmapped_write: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (wr_in && (addr_in < sicb_pkg::OFF_OVHF || addr_in > sicb_pkg::OFF_RANGE))
    |=> $stable(regs))
    else $error("unmapped write changed a register");
  a_irq_gated: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ((faults & enables) == 64'h0)
    |=> !irq_oe_out)
    else $error("interrupt driven for disabled fault");
  a_ovhf_gate: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (|(ovhf_fault_in & en_ovhf))
    |=> irq_oe_out)
    else $error("enabled hf fault gave no interrupt");
  a_ovlf_gate: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (|(ovlf_fault_in & en_ovlf))
    |=> irq_oe_out)
    else $error("enabled lf fault gave no interrupt");
  a_son_gate: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (|(seq_on_fault_in & en_son[5:0]))
    |=> irq_oe_out)
    else $error("enabled power-on fault gave no interrupt");
  a_soff_gate: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (|(seq_off_fault_in & en_soff[5:0]))
    |=> irq_oe_out)
    else $error("enabled power-off fault gave no interrupt");
  a_sex_gate: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (|(slp_exit_fault_in & en_sex[5:0]))
    |=> irq_oe_out)
    else $error("enabled sleep-exit fault gave no interrupt");
  a_sen_gate: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (|(slp_entry_fault_in & en_sen[5:0]))
    |=> irq_oe_out)
    else $error("enabled sleep-entry fault gave no interrupt");
  a_crc_gate: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (checksum_fault_in && en_ctl[sicb_pkg::CTL_CRC_BIT])
    |=> irq_oe_out)
    else $error("enabled checksum fault gave no interrupt");
  a_irq_raised: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (overtemp_fault_in && en_ctl[sicb_pkg::CTL_TSD_BIT])
    |=> irq_oe_out)
    else $error("enabled overtemp fault gave no interrupt");
  a_sync_gate: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (sync_pin_fault_in && en_ctl[sicb_pkg::CTL_SYNC_BIT])
    |=> irq_oe_out)
    else $error("enabled sync fault gave no interrupt");
  a_pec_gate: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (packet_check_fault_in && en_ctl[sicb_pkg::CTL_PEC_BIT])
    |=> irq_oe_out)
    else $error("enabled packet fault gave no interrupt");
  a_ecc_gate: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (corrected_bit_fault_in && en_tst[sicb_pkg::TST_ECC_BIT])
    |=> irq_oe_out)
    else $error("enabled corrected-bit event gave no interrupt");
  a_test_gate: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    ((selftest_fail_in && en_tst[sicb_pkg::TST_FAIL_BIT])
     || (selftest_done_in && en_tst[sicb_pkg::TST_DONE_BIT]))
    |=> irq_oe_out)
    else $error("enabled selftest event gave no interrupt");
  a_range_decode: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (channel_range_scaling_out[thr_ch_in] && thr_code_in == 8'hFF
     && $stable(channel_range_scaling_out))
    |=> thr_mv_out == 13'h170C)
    else $error("4x threshold top code wrong");
  a_range_floor: assert property (
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (!channel_range_scaling_out[thr_ch_in] && thr_code_in == 8'h00)
    |=> thr_mv_out == 13'h00C8)
    else $error("1x threshold bottom code wrong");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_hf_irq: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (|(ovhf_fault_in & en_ovhf)) ##1 irq_oe_out);
  c_seq_write: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    wr_in && addr_in == sicb_pkg::OFF_SEQ_OFF);
  c_range_4x: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    |channel_range_scaling_out);
  c_ecc_irq: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    corrected_bit_fault_in && en_tst[sicb_pkg::TST_ECC_BIT]);
  c_crc_irq: cover property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    checksum_fault_in && en_ctl[sicb_pkg::CTL_CRC_BIT]);
endmodule

// ==== rtl/sicb_irq_gate.sv ====
// gates raw fault events onto an active-low open-drain interrupt
`timescale 1ns/1ps
module sicb_irq_gate (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [63:0] fault_in,
  input wire logic [63:0] enable_in,
  output logic irq_n_out,
  output logic irq_oe_out
);
  logic any_r;

  // registered so a combinational glitch never reaches the pin
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      any_r <= 1'b0;
    else
      any_r <= |(fault_in & enable_in);
  end

  // open drain: pin only ever pulled low
  assign irq_n_out = 1'b0;
  assign irq_oe_out = any_r;
endmodule

// ==== rtl/sicb_pkg.sv ====
// package: register map, field positions, reset values and widths
package sicb_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 8;
  localparam int NUM_SEQ_CH = 6;
  localparam int NUM_REGS = 11;
  localparam logic [7:0] OFF_OVHF = 8'h15;
  localparam logic [7:0] OFF_OVLF = 8'h16;
  localparam logic [7:0] OFF_SEQ_ON = 8'h17;
  localparam logic [7:0] OFF_SEQ_OFF = 8'h18;
  localparam logic [7:0] OFF_SLP_EXIT = 8'h19;
  localparam logic [7:0] OFF_SLP_ENTRY = 8'h1A;
  localparam logic [7:0] OFF_CONTROL = 8'h1B;
  localparam logic [7:0] OFF_TEST = 8'h1C;
  localparam logic [7:0] OFF_VENDOR = 8'h1D;
  localparam logic [7:0] OFF_MON_EN = 8'h1E;
  localparam logic [7:0] OFF_RANGE = 8'h1F;
  // writable bits of each register; all others read zero
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_SEQ = 8'h3F;
  localparam logic [7:0] MASK_CONTROL = 8'h17;
  localparam logic [7:0] MASK_TEST = 8'h0B;
  localparam logic [7:0] MASK_VENDOR = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // control-fault enable bit positions
  localparam int CTL_PEC_BIT = 0;
  localparam int CTL_SYNC_BIT = 1;
  localparam int CTL_TSD_BIT = 2;
  localparam int CTL_CRC_BIT = 4;
  // test-fault enable bit positions
  localparam int TST_FAIL_BIT = 0;
  localparam int TST_DONE_BIT = 1;
  localparam int TST_ECC_BIT = 3;
  // threshold scaling: step and base in mV for 1x and 4x
  localparam int STEP_1X_MV = 5;
  localparam int STEP_4X_MV = 20;
  localparam int BASE_1X_MV = 200;
  localparam int BASE_4X_MV = 800;
  localparam int MV_W = 13;
  typedef enum logic [3:0] {
    SICB_IDX_OVHF,
    SICB_IDX_OVLF,
    SICB_IDX_SEQ_ON,
    SICB_IDX_SEQ_OFF,
    SICB_IDX_SLP_EXIT,
    SICB_IDX_SLP_ENTRY,
    SICB_IDX_CONTROL,
    SICB_IDX_TEST,
    SICB_IDX_VENDOR,
    SICB_IDX_MON_EN,
    SICB_IDX_RANGE,
    SICB_IDX_NONE
  } sicb_idx_t;
endpackage

// ==== rtl/sicb_reg_mem.sv ====
// small register memory with masked writes and registered read data
`timescale 1ns/1ps
module sicb_reg_mem (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic wr_en_in,
  input wire logic [3:0] wr_idx_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] wr_mask_in,
  input wire logic rd_en_in,
  input wire logic [3:0] rd_idx_in,
  input wire logic [7:0] rd_mask_in,
  output logic [7:0] rd_data_out,
  output logic [87:0] all_regs_out
);
  logic [7:0] mem_r [sicb_pkg::NUM_REGS];

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int i = 0; i < sicb_pkg::NUM_REGS; i++)
        mem_r[i] <= sicb_pkg::RST_ZERO;
    end
    else if (wr_en_in && (int'(wr_idx_in) < sicb_pkg::NUM_REGS))
    begin
      // reserved bits never store
      mem_r[wr_idx_in] <= wr_data_in & wr_mask_in;
    end
  end

  // unmapped reads return zero
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rd_data_out <= 8'h00;
    else if (rd_en_in && (int'(rd_idx_in) < sicb_pkg::NUM_REGS))
      rd_data_out <= mem_r[rd_idx_in] & rd_mask_in;
    else
      rd_data_out <= 8'h00;
  end

  always_comb
  begin
    for (int i = 0; i < sicb_pkg::NUM_REGS; i++)
      all_regs_out[i*8 +: 8] = mem_r[i];
  end
endmodule

// ==== tb/tb_sicb_bank.sv ====
// self-checking testbench for the interrupt-enable and configuration bank
`timescale 1ns/1ps
module tb_sicb_bank;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_sys_in;
  logic arst_n_in;
  logic [7:0] addr_in;
  logic [7:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [7:0] rdata_out;
  logic [63:0] flt;
  logic [2:0] thr_ch_in;
  logic [7:0] thr_code_in;
  logic [12:0] thr_mv_out;
  logic [7:0] mon_out;
  logic [7:0] rng_out;
  logic irq_n_out;
  logic irq_oe_out;
  logic [7:0] reg_model [11];
  logic [7:0] wmask [11] = '{8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h17, 8'h0B, 8'h00,
    8'hFF, 8'hFF};
  int num_errors = 0;
  int checks_done = 0;
  int seed = 78;
  // ----------------------------------------
  // design under test
  // ----------------------------------------
  sicb_bank u_sicb_bank (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .ovhf_fault_in(flt[7:0]), .ovlf_fault_in(flt[15:8]), .seq_on_fault_in(flt[21:16]),
    .seq_off_fault_in(flt[27:22]), .slp_exit_fault_in(flt[33:28]),
    .slp_entry_fault_in(flt[39:34]), .checksum_fault_in(flt[40]),
    .overtemp_fault_in(flt[41]), .sync_pin_fault_in(flt[42]),
    .packet_check_fault_in(flt[43]), .corrected_bit_fault_in(flt[44]),
    .selftest_done_in(flt[45]), .selftest_fail_in(flt[46]), .thr_ch_in(thr_ch_in),
    .thr_code_in(thr_code_in), .thr_mv_out(thr_mv_out), .channel_monitor_enable_out(mon_out),
    .channel_range_scaling_out(rng_out), .irq_n_out(irq_n_out), .irq_oe_out(irq_oe_out));
  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [7:0] exp_of(input logic [7:0] a);
    if (a >= 8'h15 && a <= 8'h1F)
      return reg_model[a - 8'h15];
    return 8'h00;
  endfunction
  // lane order matches the fault vector wiring above
  function automatic logic [63:0] envec();
    return {17'h0, reg_model[7][0], reg_model[7][1], reg_model[7][3], reg_model[6][0],
      reg_model[6][1], reg_model[6][2], reg_model[6][4], reg_model[5][5:0], reg_model[4][5:0],
      reg_model[3][5:0], reg_model[2][5:0], reg_model[1], reg_model[0]};
  endfunction
  function automatic logic [12:0] exp_thr(input logic [2:0] c, input logic [7:0] k);
    if (reg_model[10][c])
      return 13'(800 + 20 * k);
    return 13'(200 + 5 * k);
  endfunction
  // ----------------------------------------
  // compare tasks and run end
  // ----------------------------------------
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch reg t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_irq(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch irq t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_thr(input logic [12:0] got, input logic [12:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch thr t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
  endtask
  // read data stands one cycle only, then returns to zero
  task automatic rd_chk(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge clk_sys_in);
    cmp_reg(rdata_out, exp_of(a));
    @(negedge clk_sys_in);
    cmp_reg(rdata_out, 8'h00);
  endtask
  task automatic wr_reg(input int i, input logic [7:0] d);
    bus(1'b1, 1'b0, 8'(8'h15 + i), d);
    reg_model[i] = d & wmask[i];
  endtask
  task automatic do_reset();
    @(posedge clk_sys_in);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    foreach (reg_model[i]) reg_model[i] = 8'h00;
  endtask
  task automatic irq_chk(input logic [63:0] v);
    @(posedge clk_sys_in);
    flt <= v;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    cmp_irq(irq_oe_out, |(v & envec()));
    cmp_irq(irq_n_out, 1'b0);
  endtask
  task automatic thr_chk(input logic [2:0] c, input logic [7:0] k);
    @(posedge clk_sys_in);
    thr_ch_in <= c;
    thr_code_in <= k;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    cmp_thr(thr_mv_out, exp_thr(c, k));
  endtask
  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // whole run needs well under two thousand cycles; generous margin
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    close_out();
  end
  initial
  begin
    logic [7:0] d;
    arst_n_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    flt = 64'h0;
    thr_ch_in = 3'h0;
    thr_code_in = 8'h00;
    do_reset();
    for (int i = 0; i < 11; i++) rd_chk(8'(8'h15 + i));
    // passes: all clear, all set, then random contents
    for (int it = 0; it < 8; it++)
    begin
      for (int i = 0; i < 11; i++)
      begin
        d = (it == 0) ? 8'h00 : (it == 1) ? 8'hFF : 8'($random(seed));
        wr_reg(i, d);
      end
      bus(1'b1, 1'b0, 8'h14, 8'($random(seed)));
      bus(1'b1, 1'b0, 8'h20, 8'($random(seed)));
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      for (int a = 8'h14; a <= 8'h20; a++) rd_chk(8'(a));
      cmp_reg(mon_out, reg_model[9]);
      cmp_reg(rng_out, reg_model[10]);
      for (int l = 0; l < 47; l++) irq_chk(64'h1 << l);
      for (int k = 0; k < 4; k++) irq_chk({$random(seed), $random(seed)} & 64'h0000_7FFF_FFFF_FFFF);
      thr_chk(3'($random(seed)), 8'h00);
      thr_chk(3'($random(seed)), 8'hFF);
      for (int k = 0; k < 4; k++) thr_chk(3'($random(seed)), 8'($random(seed)));
    end
    // write then read with no gap, and a write to the reserved register
    wr_reg(0, 8'h5A);
    rd_chk(8'h15);
    wr_reg(8, 8'hFF);
    rd_chk(8'h1D);
    // mid-run reset, then every fault raised: nothing may pass
    do_reset();
    irq_chk({17'h0, {47{1'b1}}});
    for (int i = 0; i < 11; i++) rd_chk(8'(8'h15 + i));
    irq_chk(64'h0);
    repeat (2) @(posedge clk_sys_in);
    close_out();
  end
endmodule
